// ### dsp_prescaler.sv
/*
 * shared constants and types of the dual-slope pwm timer, plus the prescaler
 * that turns the system clock into a one-cycle timer clock enable.
 * assumes one clock domain and an active-low asynchronous reset.
 */
package dsp_pkg;

    // =====================================================================
    // register map and layouts
    localparam int DSP_AW = 3;
    localparam int DSP_DW = 16;
    localparam logic [2:0] DSP_ADDR_CTRL = 3'h0;
    localparam logic [2:0] DSP_ADDR_CAPTOP = 3'h1;
    localparam logic [2:0] DSP_ADDR_CMPA = 3'h2;
    localparam logic [2:0] DSP_ADDR_CMPB = 3'h3;
    localparam logic [2:0] DSP_ADDR_COUNT = 3'h4;
    localparam logic [2:0] DSP_ADDR_FLAGS = 3'h5;
    localparam logic [2:0] DSP_ADDR_PINDIR = 3'h6;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [DSP_AW-1:0] addr;
        logic [DSP_DW-1:0] wdata;
    } dsp_bus_req_type;

    // ctrl: mode in [3:0], output_mode_a_field [5:4], b [7:6], clock select [10:8]
    typedef struct packed {
        logic [2:0] clk_sel;
        logic [1:0] com_b;
        logic [1:0] com_a;
        logic [3:0] mode;
    } dsp_ctrl_type;
    localparam int DSP_CTRL_W = 11;
    localparam dsp_ctrl_type DSP_CTRL_RST = '0;

    // flags: overflow [0], compare a [1], compare b [2], capture [3]
    typedef struct packed {
        logic capture;
        logic cmp_b;
        logic cmp_a;
        logic overflow;
    } dsp_flags_type;
    localparam int DSP_FLAGS_W = 4;

    // =====================================================================
    // waveform modes and output modes
    localparam logic [3:0] DSP_MODE_PC8 = 4'h1;
    localparam logic [3:0] DSP_MODE_PC9 = 4'h2;
    localparam logic [3:0] DSP_MODE_PC10 = 4'h3;
    localparam logic [3:0] DSP_MODE_PFC_CAP = 4'h8;
    localparam logic [3:0] DSP_MODE_PFC_CMPA = 4'h9;
    localparam logic [3:0] DSP_MODE_PC_CAP = 4'hA;
    localparam logic [3:0] DSP_MODE_PC_CMPA = 4'hB;
    localparam logic [15:0] DSP_TOP_8 = 16'h00FF;
    localparam logic [15:0] DSP_TOP_9 = 16'h01FF;
    localparam logic [15:0] DSP_TOP_10 = 16'h03FF;
    localparam logic [15:0] DSP_BOTTOM = 16'h0000;
    localparam logic [15:0] DSP_VAL_RST = 16'h0000;
    localparam logic [1:0] DSP_COM_OFF = 2'h0;
    localparam logic [1:0] DSP_COM_TOGGLE = 2'h1;
    localparam logic [1:0] DSP_COM_INV = 2'h3;

    // =====================================================================
    // prescaler: select code to last count of the divider (divide minus one)
    localparam logic [2:0] DSP_CS_STOP = 3'h0;
    localparam int DSP_PRE_W = 10;
    localparam logic [9:0] DSP_LAST_1 = 10'h000;
    localparam logic [9:0] DSP_LAST_8 = 10'h007;
    localparam logic [9:0] DSP_LAST_64 = 10'h03F;
    localparam logic [9:0] DSP_LAST_256 = 10'h0FF;
    localparam logic [9:0] DSP_LAST_1024 = 10'h3FF;

    function automatic logic [9:0] dsp_div_last(input logic [2:0] sel);
        unique case (sel)
            3'h1: dsp_div_last = DSP_LAST_1;
            3'h2: dsp_div_last = DSP_LAST_8;
            3'h3: dsp_div_last = DSP_LAST_64;
            3'h4: dsp_div_last = DSP_LAST_256;
            default: dsp_div_last = DSP_LAST_1024;
        endcase
    endfunction

    function automatic logic dsp_is_pfc(input logic [3:0] mode);
        dsp_is_pfc = (mode == DSP_MODE_PFC_CAP) || (mode == DSP_MODE_PFC_CMPA);
    endfunction

    function automatic logic dsp_is_dual(input logic [3:0] mode);
        dsp_is_dual = dsp_is_pfc(mode) || (mode == DSP_MODE_PC8) || (mode == DSP_MODE_PC9)
            || (mode == DSP_MODE_PC10) || (mode == DSP_MODE_PC_CAP) || (mode == DSP_MODE_PC_CMPA);
    endfunction

    function automatic logic dsp_top_is_cmpa(input logic [3:0] mode);
        dsp_top_is_cmpa = (mode == DSP_MODE_PFC_CMPA) || (mode == DSP_MODE_PC_CMPA);
    endfunction

    function automatic logic dsp_top_is_cap(input logic [3:0] mode);
        dsp_top_is_cap = (mode == DSP_MODE_PFC_CAP) || (mode == DSP_MODE_PC_CAP);
    endfunction

endpackage

`timescale 1ns/1ps
`default_nettype none

module dsp_prescaler
    import dsp_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_resetn,
    input wire logic [2:0] i_clk_sel,
    output logic o_tick
);

    // =====================================================================
    // state
    typedef struct packed {
        logic [DSP_PRE_W-1:0] cnt;
        logic tick;
    } dsp_pre_state_type;

    dsp_pre_state_type st_q;
    dsp_pre_state_type st_d;

    always_comb begin
        st_d = st_q;
        st_d.tick = 1'b0;
        if (i_clk_sel == DSP_CS_STOP || i_clk_sel > 3'h5) begin
            st_d.cnt = '0;
        end else if (st_q.cnt >= dsp_div_last(i_clk_sel)) begin
            st_d.cnt = '0;
            st_d.tick = 1'b1;
        end else begin
            st_d.cnt = st_q.cnt + 10'h001;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign o_tick = st_q.tick;

endmodule

`default_nettype wire

// ### dsp_pwm_timer.sv
/*
 * dual-slope 16-bit pwm timer: phase-correct and phase-and-frequency-correct
 * modes, two compare channels, register port, pin gating.
 * assumes a single-master register port on the same clock and that the pin
 * pad combines value and active-low output enable.
 */
// The register addresses and the plain strobed port were decided locally.
// Functional notes
// - timer clock enable from prescaler dividing by 1, 8, 64, 256 or 1024
// - phase-correct non-inverted: compare at bottom low, at top high
// - inverted output gives opposite levels at both extreme compare values
// - mode 11 with channel a output mode 1 toggles a on match
// - modes 8 and 9 count up from zero to top and back down
// - non-inverting clears on up match, sets on down match; inverting reversed
// - output mode two is non-inverted pwm, three inverted pwm
// - top is capture value in mode 8, compare a in mode 9
// - counter holds top for exactly one timer clock before counting down
// - compare flag set on every match, rising and falling slopes
// - overflow flag set with compare reload at bottom in modes 8 and 9
// - compare a or capture flag, whichever defines top, set when counter reaches top
// - compare output reaches pin only when direction bit selects output
// - period is twice prescale factor times top
// - frequency-correct non-inverted: bottom compare low, top compare high
// - mode 9 with channel a output mode 1 toggles a on match
// - fully synchronous, prescaled clock only qualifies counting, flags, compare outputs and compare reload
// - capture top written directly, compare writes buffered until update point
`timescale 1ns/1ps
`default_nettype none

module dsp_pwm_timer
    import dsp_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_resetn,
    input wire dsp_bus_req_type i_bus,
    output logic [DSP_DW-1:0] o_rdata,
    output logic o_pin_a,
    output logic o_pin_a_oe_n,
    output logic o_pin_b,
    output logic o_pin_b_oe_n
);

    // =====================================================================
    // state
    typedef enum logic {
        DSP_CNT_UP = 1'b0,
        DSP_CNT_DOWN = 1'b1
    } dsp_dir_type;

    typedef struct packed {
        dsp_ctrl_type ctrl;
        logic [15:0] cap_top;
        logic [15:0] cmp_a;
        logic [15:0] cmp_b;
        logic [15:0] buf_a;
        logic [15:0] buf_b;
        logic [15:0] cnt;
        dsp_dir_type dir;
        dsp_flags_type flags;
        logic [1:0] pin_dir;
        logic out_a;
        logic out_b;
        logic [DSP_DW-1:0] rdata;
    } dsp_state_type;

    dsp_state_type st_q;
    dsp_state_type st_d;
    logic tick;
    logic [15:0] top;
    logic at_top;
    logic at_bottom;
    logic update_pt;
    logic match_a;
    logic match_b;
    logic dual;
    dsp_flags_type set_f;
    dsp_flags_type clr_f;

    // =====================================================================
    // prescaler
    dsp_prescaler dsp_prescaler_inst (
        .i_sys_clk(i_sys_clk),
        .i_resetn(i_resetn),
        .i_clk_sel(st_q.ctrl.clk_sel),
        .o_tick(tick)
    );

    // =====================================================================
    // top and event decode
    always_comb begin
        unique case (st_q.ctrl.mode)
            DSP_MODE_PC8: top = DSP_TOP_8;
            DSP_MODE_PC9: top = DSP_TOP_9;
            DSP_MODE_PC10: top = DSP_TOP_10;
            DSP_MODE_PFC_CMPA,
            DSP_MODE_PC_CMPA: top = st_q.cmp_a;
            default: top = st_q.cap_top;
        endcase
    end

    assign dual = dsp_is_dual(st_q.ctrl.mode);
    assign at_top = dual && (st_q.dir == DSP_CNT_UP) && (st_q.cnt == top);
    assign at_bottom = dual && (st_q.dir == DSP_CNT_DOWN) && (st_q.cnt == DSP_BOTTOM);
    // reload point: bottom or top by mode
    assign update_pt = tick && (dsp_is_pfc(st_q.ctrl.mode) ? at_bottom : at_top);
    assign match_a = tick && dual && (st_q.cnt == st_q.cmp_a);
    assign match_b = tick && dual && (st_q.cnt == st_q.cmp_b);

    always_comb begin
        set_f = '0;
        set_f.overflow = tick && at_bottom;
        set_f.cmp_a = match_a || (tick && at_top && dsp_top_is_cmpa(st_q.ctrl.mode));
        set_f.cmp_b = match_b;
        set_f.capture = tick && at_top && dsp_top_is_cap(st_q.ctrl.mode);
        clr_f = '0;
        if (i_bus.wr && i_bus.addr == DSP_ADDR_FLAGS) begin
            clr_f = dsp_flags_type'(i_bus.wdata[DSP_FLAGS_W-1:0]);
        end
    end

    // =====================================================================
    // output level on a compare match
    function automatic logic dsp_match_level(input logic [1:0] com, input logic [15:0] cmp,
                                            input logic [15:0] tv, input dsp_dir_type dir,
                                            input logic cur);
        logic inv;
        inv = (com == DSP_COM_INV);
        if (com == DSP_COM_TOGGLE) begin
            dsp_match_level = ~cur;
        end else if (cmp == tv) begin
            // same extreme in both dual modes
            dsp_match_level = ~inv;
        end else if (cmp == DSP_BOTTOM) begin
            dsp_match_level = inv;
        end else begin
            dsp_match_level = (dir == DSP_CNT_UP) ? inv : ~inv;
        end
    endfunction

    // =====================================================================
    // next state
    always_comb begin
        st_d = st_q;

        // counter, runs only on the timer clock enable
        if (tick && dual) begin
            if (st_q.dir == DSP_CNT_UP) begin
                if (st_q.cnt == top) begin
                    st_d.dir = DSP_CNT_DOWN;
                    st_d.cnt = st_q.cnt - 16'h0001;
                end else begin
                    // rising slope, wraps past max if top was lowered below
                    st_d.cnt = st_q.cnt + 16'h0001;
                end
            end else if (st_q.cnt == DSP_BOTTOM) begin
                st_d.dir = DSP_CNT_UP;
                st_d.cnt = st_q.cnt + 16'h0001;
            end else begin
                st_d.cnt = st_q.cnt - 16'h0001;
            end
        end

        if (update_pt) begin
            st_d.cmp_a = st_q.buf_a;
            st_d.cmp_b = st_q.buf_b;
        end

        // compare output modes one to three; mode 1 toggles channel a only
        if (match_a && st_q.ctrl.com_a != DSP_COM_OFF) begin
            // toggle a only when compare a is top
            if (st_q.ctrl.com_a != DSP_COM_TOGGLE || dsp_top_is_cmpa(st_q.ctrl.mode)) begin
                st_d.out_a = dsp_match_level(st_q.ctrl.com_a, st_q.cmp_a, top, st_q.dir, st_q.out_a);
            end
        end
        // toggle is a channel-a feature; b ignores output mode 1
        if (match_b && st_q.ctrl.com_b != DSP_COM_OFF && st_q.ctrl.com_b != DSP_COM_TOGGLE) begin
            st_d.out_b = dsp_match_level(st_q.ctrl.com_b, st_q.cmp_b, top, st_q.dir, st_q.out_b);
        end

        st_d.flags = (st_q.flags & ~clr_f) | set_f;

        // register writes
        if (i_bus.wr) begin
            unique case (i_bus.addr)
                DSP_ADDR_CTRL: st_d.ctrl = dsp_ctrl_type'(i_bus.wdata[DSP_CTRL_W-1:0]);
                DSP_ADDR_CAPTOP: st_d.cap_top = i_bus.wdata;
                DSP_ADDR_CMPA: st_d.buf_a = i_bus.wdata;
                DSP_ADDR_CMPB: st_d.buf_b = i_bus.wdata;
                DSP_ADDR_COUNT: st_d.cnt = i_bus.wdata;
                DSP_ADDR_PINDIR: st_d.pin_dir = i_bus.wdata[1:0];
                default: ;
            endcase
        end

        // read data stand one cycle after the strobe only
        st_d.rdata = '0;
        if (i_bus.rd) begin
            unique case (i_bus.addr)
                DSP_ADDR_CTRL: st_d.rdata = {5'h0, st_q.ctrl};
                DSP_ADDR_CAPTOP: st_d.rdata = st_q.cap_top;
                // software sees the buffer it wrote, not the active copy
                DSP_ADDR_CMPA: st_d.rdata = st_q.buf_a;
                DSP_ADDR_CMPB: st_d.rdata = st_q.buf_b;
                DSP_ADDR_COUNT: st_d.rdata = st_q.cnt;
                DSP_ADDR_FLAGS: st_d.rdata = {12'h000, st_q.flags};
                DSP_ADDR_PINDIR: st_d.rdata = {14'h0, st_q.pin_dir};
                default: st_d.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            st_q <= '{ctrl: DSP_CTRL_RST, cap_top: DSP_VAL_RST, cmp_a: DSP_VAL_RST,
                      cmp_b: DSP_VAL_RST, buf_a: DSP_VAL_RST, buf_b: DSP_VAL_RST,
                      cnt: DSP_BOTTOM, dir: DSP_CNT_UP, flags: '0, pin_dir: 2'h0,
                      out_a: 1'b0, out_b: 1'b0, rdata: '0};
        end else begin
            st_q <= st_d;
        end
    end

    // =====================================================================
    // pins
    assign o_rdata = st_q.rdata;
    assign o_pin_a = st_q.out_a;
    assign o_pin_b = st_q.out_b;
    // pin driven only when direction is output and channel connected
    assign o_pin_a_oe_n = ~(st_q.pin_dir[0] && st_q.ctrl.com_a != DSP_COM_OFF);
    assign o_pin_b_oe_n = ~(st_q.pin_dir[1] && st_q.ctrl.com_b != DSP_COM_OFF);

    // period 2*N*top follows from one tick per count step

endmodule

`default_nettype wire

// ### dsp_pwm_chk.sv
/*
 * port checker of the dual-slope pwm timer, bound at the foot.
 * assumes one clock, active-low async reset, one register master.
 */
`timescale 1ns/1ps
`default_nettype none

module dsp_pwm_chk
    import dsp_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_resetn,
    input wire dsp_bus_req_type i_bus,
    input wire logic [DSP_DW-1:0] o_rdata,
    input wire logic o_pin_a,
    input wire logic o_pin_a_oe_n,
    input wire logic o_pin_b,
    input wire logic o_pin_b_oe_n
);
    // ====================================
    // shadow of control and direction
    logic [10:0] ctrl_q;
    logic [1:0] dir_q;
    logic rd_q;
    logic on_a;
    logic on_b;
    logic stop;
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            ctrl_q <= '0;
            dir_q <= '0;
            rd_q <= 1'b0;
        end else begin
            rd_q <= i_bus.rd;
            if (i_bus.wr && i_bus.addr == DSP_ADDR_CTRL) begin
                ctrl_q <= i_bus.wdata[10:0];
            end
            if (i_bus.wr && i_bus.addr == DSP_ADDR_PINDIR) begin
                dir_q <= i_bus.wdata[1:0];
            end
        end
    end
    // two cycles allowed, pin enable may be registered
    assign on_a = dir_q[0] && ctrl_q[5:4] != 2'h0;
    assign on_b = dir_q[1] && ctrl_q[7:6] != 2'h0;
    assign stop = ctrl_q[10:8] == 3'h0 || ctrl_q[10:8] > 3'h5;

    // ====================================
    // assertions
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_resetn);

    a_rdata_idle: assert property (!rd_q |-> o_rdata == 16'h0000)
        else $error("read data not zero outside read answer");
    a_unmapped_zero: assert property (i_bus.rd && i_bus.addr == 3'h7 |=> o_rdata == 16'h0000)
        else $error("unmapped read not zero");
    a_ctrl_readback: assert property (i_bus.rd && i_bus.addr == DSP_ADDR_CTRL |=> o_rdata == {5'h0, ctrl_q})
        else $error("control readback wrong");
    a_oe_a_on: assert property (on_a [*2] |-> !o_pin_a_oe_n)
        else $error("pin a not driven");
    a_oe_a_off: assert property (!on_a [*2] |-> o_pin_a_oe_n)
        else $error("pin a driven while disabled");
    a_oe_b_on: assert property (on_b [*2] |-> !o_pin_b_oe_n)
        else $error("pin b not driven");
    a_oe_b_off: assert property (!on_b [*2] |-> o_pin_b_oe_n)
        else $error("pin b driven while disabled");
    a_stop_frozen: assert property (stop [*3] |=> $stable(o_pin_a) && $stable(o_pin_b))
        else $error("pin moved with timer stopped");

    c_read: cover property (rd_q && o_rdata != 16'h0000);
    c_pwm_a: cover property (on_a && $rose(o_pin_a));
    c_pwm_b: cover property (on_b && $fell(o_pin_b));
endmodule

bind dsp_pwm_timer dsp_pwm_chk dsp_pwm_chk_inst (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_bus(i_bus),
    .o_rdata(o_rdata), .o_pin_a(o_pin_a), .o_pin_a_oe_n(o_pin_a_oe_n), .o_pin_b(o_pin_b),
    .o_pin_b_oe_n(o_pin_b_oe_n));

`default_nettype wire

// ### dsp_pwm_timer_tb.sv
/*
 * self-checking bench of the dual-slope pwm timer via register port and pins.
 * assumes the checker file is compiled beside it.
 */
`timescale 1ns/1ps
`default_nettype none

module dsp_pwm_timer_tb
    import dsp_pkg::*;
;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    dsp_bus_req_type bus = '0;
    logic [15:0] rdata;
    logic [15:0] r;
    logic pa, pa_oe_n, pb, pb_oe_n;
    int fail_count = 0;
    int total_checks = 0;
    int cycles = 0;
    int hi, per;
    int nf[5] = '{1, 8, 64, 256, 1024};
    logic [3:0] em[2] = '{DSP_MODE_PFC_CAP, DSP_MODE_PC_CAP};
    logic [3:0] fm[3] = '{DSP_MODE_PC8, DSP_MODE_PC9, DSP_MODE_PC10};
    int ft[3] = '{int'(DSP_TOP_8), int'(DSP_TOP_9), int'(DSP_TOP_10)};

    always #20 clk = ~clk;

    dsp_pwm_timer dsp_pwm_timer_inst (.i_sys_clk(clk), .i_resetn(rst_n), .i_bus(bus), .o_rdata(rdata),
        .o_pin_a(pa), .o_pin_a_oe_n(pa_oe_n), .o_pin_b(pb), .o_pin_b_oe_n(pb_oe_n));

    // ====================================
    // report and compare
    task automatic tally_and_finish();
        if (fail_count == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic bad(input string m);
        fail_count++;
        $display("Error at %0t: %s", $time, m);
    endtask
    task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) bad($sformatf("word %h, expected %h", got, exp));
    endtask
    task automatic chk_time(input int got, input int exp);
        total_checks++;
        if (got != exp) bad($sformatf("%0d clocks, expected %0d", got, exp));
    endtask
    task automatic chk_pin(input logic got, input logic exp);
        total_checks++;
        if (got !== exp) bad($sformatf("pin %b, expected %b", got, exp));
    endtask

    // ====================================
    // bus cycles and measurement
    task automatic step();
        @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge clk);
        bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk);
        bus <= '0;
    endtask
    task automatic rc(input logic [2:0] a, input logic [15:0] exp);
        @(posedge clk);
        bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
        @(posedge clk);
        bus <= '0;
        #1 r = rdata;
        chk_word(r, exp);
    endtask
    // first pulse skipped, compares reload only at the update point
    task automatic pwm(input bit b, input int ep, input int eh);
        hi = 0;
        repeat (2) begin
            while ((b ? pb : pa) !== 1'b0) step();
            while ((b ? pb : pa) !== 1'b1) step();
        end
        while ((b ? pb : pa) === 1'b1) begin
            step();
            hi++;
        end
        per = hi;
        while ((b ? pb : pa) === 1'b0) begin
            step();
            per++;
        end
        chk_time(per, ep);
        chk_time(hi, eh);
    endtask
    task automatic cfg(input logic [3:0] m, input logic [1:0] c, input logic [2:0] s,
                       input logic [15:0] cap, input logic [15:0] ca, input logic [15:0] cb);
        wr(DSP_ADDR_CTRL, 16'h0000);
        wr(DSP_ADDR_CAPTOP, cap);
        wr(DSP_ADDR_CMPA, ca);
        wr(DSP_ADDR_CMPB, cb);
        wr(DSP_ADDR_COUNT, 16'h0000);
        wr(DSP_ADDR_CTRL, {5'h0, s, 2'h2, c, m});
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 80000) begin
            bad("timeout");
            tally_and_finish();
        end
    end

    // ====================================
    // scenarios
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        step();
        chk_pin(pa_oe_n, 1'b1);
        chk_pin(pb, 1'b0);
        rc(DSP_ADDR_CTRL, 16'h0000);
        rc(DSP_ADDR_FLAGS, 16'h0000);
        wr(3'h7, 16'hFFFF);
        rc(3'h7, 16'h0000);
        wr(DSP_ADDR_CAPTOP, 16'h1234);
        rc(DSP_ADDR_CAPTOP, 16'h1234);
        wr(DSP_ADDR_CMPA, 16'h00A5);
        rc(DSP_ADDR_CMPA, 16'h00A5);
        wr(DSP_ADDR_COUNT, 16'h0007);
        repeat (5) step();
        rc(DSP_ADDR_COUNT, 16'h0007);
        wr(DSP_ADDR_PINDIR, 16'h0003);
        foreach (nf[i]) begin
            cfg(DSP_MODE_PFC_CAP, 2'h2, 3'(i + 1), 16'h0004, 16'h0001, 16'h0001);
            pwm(1'b0, 8 * nf[i], 2 * nf[i]);
        end
        cfg(DSP_MODE_PFC_CAP, 2'h3, 3'h1, 16'h0008, 16'h0003, 16'h0005);
        pwm(1'b0, 16, 10);
        pwm(1'b1, 16, 10);
        wr(DSP_ADDR_CTRL, 16'h0000);
        wr(DSP_ADDR_FLAGS, 16'h000F);
        rc(DSP_ADDR_FLAGS, 16'h0000);
        cfg(DSP_MODE_PFC_CMPA, 2'h2, 3'h1, 16'h0003, 16'h0008, 16'h0003);
        pwm(1'b1, 16, 6);
        wr(DSP_ADDR_CTRL, 16'h0000);
        rc(DSP_ADDR_FLAGS, 16'h0007);
        foreach (em[k]) begin
            for (int j = 0; j < 4; j++) begin
                cfg(em[k], {1'b1, j[0]}, 3'h1, 16'h0004, {13'h0, j[1], 2'h0}, 16'h0001);
                repeat (24) step();
                repeat (16) begin
                    step();
                    chk_pin(pa, j[1] ^ j[0]);
                end
            end
        end
        wr(DSP_ADDR_CTRL, 16'h0000);
        rc(DSP_ADDR_FLAGS, 16'h000F);
        cfg(DSP_MODE_PFC_CMPA, 2'h1, 3'h1, 16'h0004, 16'h0004, 16'h0001);
        pwm(1'b0, 16, 8);
        cfg(DSP_MODE_PC_CMPA, 2'h1, 3'h1, 16'h0004, 16'h0004, 16'h0001);
        pwm(1'b0, 16, 8);
        foreach (fm[k]) begin
            cfg(fm[k], 2'h2, 3'h1, 16'h0004, 16'h0080, 16'h0040);
            pwm(1'b0, 2 * ft[k], 256);
            pwm(1'b1, 2 * ft[k], 128);
        end
        chk_pin(pa_oe_n, 1'b0);
        wr(DSP_ADDR_PINDIR, 16'h0000);
        step();
        chk_pin(pa_oe_n, 1'b1);
        chk_pin(pb_oe_n, 1'b1);
        tally_and_finish();
    end
endmodule

`default_nettype wire
